// >>> src/sdec_pkg.sv
// Constants, types and reset values for the system address decoder
package sdec_pkg;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int SNW = 48;
	localparam logic [3:0]  REGION_PPB   = 4'he;
	localparam logic [31:0] ROM_LO_BASE  = 32'h0000_0000;
	localparam logic [31:0] ROM_HI_BASE  = 32'h1000_0000;
	localparam logic [31:0] ROM_SIZE     = 32'h0000_0800;
	localparam logic [31:0] FLASH_BASE   = 32'h1004_0000;
	localparam logic [31:0] FLASH_SIZE   = 32'h0002_8000;
	localparam logic [31:0] RAM0_BASE    = 32'h2000_0000;
	localparam logic [31:0] RAM1_BASE    = 32'h2000_3000;
	localparam logic [31:0] RAM_SIZE     = 32'h0000_3000;
	localparam logic [7:0]  APB_TOP      = 8'h40;
	localparam logic [3:0]  APB_RSV_A    = 4'h5;
	localparam logic [3:0]  APB_RSV_B    = 4'h6;
	localparam logic [19:0] RADIO_LINK   = 20'h48000;
	localparam logic [19:0] RADIO_CLK    = 20'h48100;
	localparam logic [19:0] DMA_PAGE     = 20'ha0000;
	localparam logic [19:0] RAND_PAGE    = 20'hb0000;
	localparam logic [31:0] KEY_REG_BASE = 32'hc000_0000;
	localparam logic [31:0] KEY_REG_SIZE = 32'h0000_0400;
	localparam logic [31:0] PKRAM_BASE   = 32'hc000_0400;
	localparam logic [31:0] PKRAM_SIZE   = 32'h0000_1000;
	localparam logic [11:0] PPB_MB       = 12'he00;
	localparam logic [7:0]  SLOT_OFF_0   = 8'h00;
	localparam logic [29:0] SN_WORD_LO   = 30'h0400_01fd;
	localparam logic [29:0] SN_WORD_HI   = 30'h0400_01fe;
	localparam logic [15:0] SN_PAD       = 16'haa55;
	localparam logic [2:0]  HSIZE_BYTE   = 3'h0;
	localparam logic [2:0]  HSIZE_HALF   = 3'h1;
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;
	localparam int NTGT = 11;

	typedef enum logic [3:0] {
		T_NONE, T_ROM, T_FLASH, T_RAM0, T_RAM1, T_APB,
		T_DMA, T_RAND, T_KEY_REG, T_PKRAM, T_PPB
	} sdec_tgt_t;

	typedef enum logic [2:0] {P_IDLE, P_TGT, P_SN, P_ERR1, P_ERR2} sdec_phase_t;

	typedef struct packed {
		logic [AW-1:0] haddr;
		logic [1:0]    htrans;
		logic          hwrite;
		logic [2:0]    hsize;
	} sdec_req_t;

	typedef struct packed {
		logic [DW-1:0] hrdata;
		logic          hready;
		logic          hresp;
	} sdec_rsp_t;

	typedef struct packed {
		sdec_phase_t   phase;
		sdec_tgt_t     dtgt;
		logic [DW-1:0] sn_word;
	} sdec_state_t;

	localparam sdec_state_t STATE_RST = '{P_IDLE, T_NONE, '0};
endpackage : sdec_pkg

// >>> src/sdec_top.sv
// System address decoder between the core bus master and its targets
`timescale 1ns/1ps
`default_nettype none
module sdec_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire sdec_pkg::sdec_req_t   req_i,
	input  wire logic [47:0]           serial_i,
	input  wire logic [31:0]           tgt_rdata_i [sdec_pkg::NTGT],
	input  wire logic [10:0]           tgt_ready_i,
	input  wire logic [10:0]           tgt_resp_i,
	output logic [10:0]                sel_o,
	output logic [3:0]                 byte_en_o,
	output sdec_pkg::sdec_rsp_t        rsp_o
);
	import sdec_pkg::*;

	sdec_state_t state_ff;
	sdec_state_t nxt_state;
	sdec_tgt_t   dec_tgt;
	logic        accept;
	logic        is_fast;
	logic        is_code;
	logic        sn_hit;
	logic        bad;
	logic [3:0]  be_half;

	function automatic logic in_win(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] size);
		in_win = (a >= base) && (a - base < size);
	endfunction : in_win

	// Region first, then window inside it; anything unmatched stays T_NONE
	always_comb begin
		dec_tgt = T_NONE;
		case (req_i.haddr[31:28])
			4'h0: begin
				if (in_win(req_i.haddr, ROM_LO_BASE, ROM_SIZE))
					dec_tgt = T_ROM;
			end
			4'h1: begin
				if (in_win(req_i.haddr, ROM_HI_BASE, ROM_SIZE))
					dec_tgt = T_ROM;
				else if (in_win(req_i.haddr, FLASH_BASE, FLASH_SIZE))
					dec_tgt = T_FLASH;
			end
			4'h2: begin
				// Above the second bank nothing answers
				if (in_win(req_i.haddr, RAM0_BASE, RAM_SIZE))
					dec_tgt = T_RAM0;
				else if (in_win(req_i.haddr, RAM1_BASE, RAM_SIZE))
					dec_tgt = T_RAM1;
			end
			4'h4: begin
				if (req_i.haddr[31:24] == APB_TOP &&
					req_i.haddr[19:12] == SLOT_OFF_0 &&
					req_i.haddr[23:20] != APB_RSV_A &&
					req_i.haddr[23:20] != APB_RSV_B)
					dec_tgt = T_APB;
				else if (req_i.haddr[31:12] == RADIO_LINK ||
					req_i.haddr[31:12] == RADIO_CLK)
					dec_tgt = T_APB;
			end
			4'ha: begin
				if (req_i.haddr[31:12] == DMA_PAGE)
					dec_tgt = T_DMA;
			end
			4'hb: begin
				if (req_i.haddr[31:12] == RAND_PAGE)
					dec_tgt = T_RAND;
			end
			4'hc: begin
				if (in_win(req_i.haddr, KEY_REG_BASE, KEY_REG_SIZE))
					dec_tgt = T_KEY_REG;
				else if (in_win(req_i.haddr, PKRAM_BASE, PKRAM_SIZE))
					dec_tgt = T_PKRAM;
			end
			REGION_PPB: begin
				if (req_i.haddr[31:20] == PPB_MB)
					dec_tgt = T_PPB;
			end
			default: dec_tgt = T_NONE;
		endcase
	end

	// Fast-bus targets have no byte lanes, so narrow accesses must fault
	assign is_fast = (dec_tgt == T_DMA) || (dec_tgt == T_RAND) ||
		(dec_tgt == T_KEY_REG) || (dec_tgt == T_PKRAM);
	assign is_code = (dec_tgt == T_ROM) || (dec_tgt == T_FLASH);
	assign sn_hit  = !req_i.hwrite && (req_i.haddr[31:2] == SN_WORD_LO ||
		req_i.haddr[31:2] == SN_WORD_HI);
	assign accept  = rsp_o.hready && req_i.htrans[1];
	assign bad     = (dec_tgt == T_NONE) ||
		(is_fast && req_i.hsize != HSIZE_WORD) ||
		(is_code && req_i.hwrite);

	// Target selects follow the address phase; an erroring access selects none
	generate
		for (genvar g = 0; g < NTGT; g++) begin : g_sel
			assign sel_o[g] = accept && !bad && !sn_hit &&
				(dec_tgt == sdec_tgt_t'(g));
		end
	endgenerate

	// Little-endian lanes: lane n carries the byte at address offset n
	always_comb begin
		be_half = req_i.haddr[1] ? 4'hc : 4'h3;
		case (req_i.hsize)
			HSIZE_BYTE: byte_en_o = 4'h1 << req_i.haddr[1:0];
			HSIZE_HALF: byte_en_o = be_half;
			default:    byte_en_o = 4'hf;
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff.phase)
			P_ERR1:  nxt_state.phase = P_ERR2;
			default: begin
				if (accept) begin
					nxt_state.dtgt = dec_tgt;
					if (bad)
						nxt_state.phase = P_ERR1;
					else if (sn_hit)
						nxt_state.phase = P_SN;
					else
						nxt_state.phase = P_TGT;
					// Serial bytes 0..3 low word; bytes 4,5 then the pad
					if (req_i.haddr[31:2] == SN_WORD_LO)
						nxt_state.sn_word = serial_i[31:0];
					else
						nxt_state.sn_word = {SN_PAD, serial_i[47:32]};
				end else if (rsp_o.hready) begin
					nxt_state.phase = P_IDLE;
					nxt_state.dtgt  = T_NONE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			state_ff <= STATE_RST;
		else
			state_ff <= nxt_state;
	end

	// Two-cycle error: hold the master once, then release with the error
	always_comb begin
		rsp_o.hrdata = '0;
		rsp_o.hready = 1'b1;
		rsp_o.hresp  = 1'b0;
		case (state_ff.phase)
			P_TGT: begin
				rsp_o.hrdata = tgt_rdata_i[state_ff.dtgt];
				rsp_o.hready = tgt_ready_i[state_ff.dtgt];
				rsp_o.hresp  = tgt_resp_i[state_ff.dtgt];
			end
			P_SN:    rsp_o.hrdata = state_ff.sn_word;
			P_ERR1: begin
				rsp_o.hready = 1'b0;
				rsp_o.hresp  = 1'b1;
			end
			P_ERR2:  rsp_o.hresp  = 1'b1;
			default: rsp_o.hresp  = 1'b0;
		endcase
	end

	a_reserved_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && dec_tgt == T_NONE |=> !rsp_o.hready && rsp_o.hresp
		##1 rsp_o.hready && rsp_o.hresp)
		else $error("reserved access lacks two-cycle error");

	a_high_region: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:28] == 4'hf |-> sel_o == '0)
		else $error("top region selected a target");

	a_narrow_fast: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == RAND_PAGE &&
		req_i.hsize != HSIZE_WORD |-> sel_o == '0 ##1 rsp_o.hresp)
		else $error("narrow fast-bus access not faulted");

	a_code_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.hwrite && req_i.haddr < ROM_SIZE
		|=> state_ff.phase == P_ERR1)
		else $error("boot ROM write not faulted");

	a_sel_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$onehot0(sel_o) && !sel_o[T_NONE])
		else $error("select not one-hot");

	a_ram_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr == RAM1_BASE |-> sel_o[T_RAM1])
		else $error("second bank base not routed");

	a_ppb_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:20] == PPB_MB |-> sel_o[T_PPB])
		else $error("private span not routed");

	a_serial_pad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && !req_i.hwrite && req_i.haddr[31:2] == SN_WORD_HI
		|=> rsp_o.hready && rsp_o.hrdata[31:16] == SN_PAD &&
		rsp_o.hrdata[15:0] == $past(serial_i[47:32]))
		else $error("serial high word wrong");

	a_apb_hole: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:20] == 12'h405 |-> !sel_o[T_APB])
		else $error("reserved bridge slot selected");

	a_byte_lane: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.hsize == HSIZE_BYTE && req_i.haddr[1:0] == 2'h3
		|-> byte_en_o == 4'h8)
		else $error("little-endian lane wrong");

	a_half_lane: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.hsize == HSIZE_HALF && req_i.haddr[1]
		|-> byte_en_o == 4'hc)
		else $error("upper half lanes wrong");

	a_word_lane: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.hsize == HSIZE_WORD
		|-> byte_en_o == 4'hf)
		else $error("word lanes wrong");

	a_rom_hi_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && !req_i.hwrite && req_i.haddr == ROM_HI_BASE
		|-> sel_o[T_ROM])
		else $error("upper boot copy not routed");

	a_flash_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && !req_i.hwrite && req_i.haddr == FLASH_BASE
		|-> sel_o[T_FLASH])
		else $error("flash base not routed");

	a_flash_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.hwrite && req_i.haddr == FLASH_BASE
		|-> sel_o == '0 ##1 !rsp_o.hready && rsp_o.hresp)
		else $error("flash write not faulted");

	a_ram0_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr == RAM0_BASE
		|-> sel_o[T_RAM0])
		else $error("first bank base not routed");

	a_ram_hole: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:28] == 4'h2 &&
		req_i.haddr >= RAM1_BASE + RAM_SIZE |-> sel_o == '0)
		else $error("space above the banks selected");

	a_radio_link: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == RADIO_LINK
		|-> sel_o[T_APB])
		else $error("radio link window not routed");

	a_radio_clock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == RADIO_CLK
		|-> sel_o[T_APB])
		else $error("radio clock window not routed");

	a_dma_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == DMA_PAGE &&
		req_i.hsize == HSIZE_WORD |-> sel_o[T_DMA])
		else $error("dma page not routed");

	a_rand_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == RAND_PAGE &&
		req_i.hsize == HSIZE_WORD |-> sel_o[T_RAND])
		else $error("random source not routed");

	a_work_ram: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr == PKRAM_BASE &&
		req_i.hsize == HSIZE_WORD |-> sel_o[T_PKRAM])
		else $error("key work ram not routed");

	a_fast_direct: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:28] inside {4'ha, 4'hb, 4'hc}
		|-> !sel_o[T_APB])
		else $error("fast-bus address sent to bridge");

	a_slot_hole: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:20] == {APB_TOP, APB_RSV_B}
		|-> !sel_o[T_APB])
		else $error("second reserved slot selected");

	a_slot_41: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:12] == 20'h41000
		|-> sel_o == '0)
		else $error("reserved slot above bridge selected");

	a_serial_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && !req_i.hwrite && req_i.haddr[31:2] == SN_WORD_LO
		|=> rsp_o.hrdata == $past(serial_i[31:0]))
		else $error("serial low word wrong");

	a_ppb_above: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:28] == REGION_PPB &&
		req_i.haddr[31:20] != PPB_MB |-> sel_o == '0)
		else $error("space above private span selected");

	a_empty_region: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accept && req_i.haddr[31:28] == 4'h3
		|-> sel_o == '0)
		else $error("empty region selected");
endmodule : sdec_top
`default_nettype wire

// >>> bench/sdec_master.sv
// Core-side bus master model issuing single transfers
`timescale 1ns/1ps
`default_nettype none
module sdec_master (
	input  wire logic                clk_i,
	input  wire sdec_pkg::sdec_rsp_t rsp_i,
	input  wire logic [10:0]         sel_i,
	input  wire logic [3:0]          be_i,
	output var sdec_pkg::sdec_req_t  req_o
);
	import sdec_pkg::*;
	initial req_o = '0;
	// Address held until taken, then data phase polled to its end
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [2:0] sz, output logic [10:0] sel, output logic [3:0] be,
		output logic [31:0] rd, output logic er, output int wt);
		int n;
		n = 0;
		@(negedge clk_i);
		req_o = '{a, 2'h2, w, sz};
		#1;
		while (rsp_i.hready !== 1'b1 && n < 50) begin
			@(negedge clk_i);
			#1;
			n++;
		end
		sel = sel_i;
		be = be_i;
		@(negedge clk_i);
		// Idle beat: address is don't-care, so show a changed value
		req_o = '{~a, 2'h0, ~w, sz};
		wt = 0;
		#1;
		while (rsp_i.hready !== 1'b1 && wt < 50) begin
			@(negedge clk_i);
			#1;
			wt++;
		end
		rd = rsp_i.hrdata;
		er = rsp_i.hresp;
	endtask : xfer
endmodule : sdec_master
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sdec_pkg::*;
	localparam logic [47:0] SER = 48'h6655_4433_2211;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	sdec_req_t   req;
	sdec_rsp_t   rsp;
	logic [31:0] trd [NTGT];
	logic [10:0] sel;
	logic [3:0]  be;
	logic [10:0] trdy = 11'h7ff;
	logic [10:0] trsp = 11'h000;
	int          err_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	always #5 clk_i = ~clk_i;
	sdec_master i_sdec_master (.clk_i(clk_i), .rsp_i(rsp), .sel_i(sel),
		.be_i(be), .req_o(req));
	sdec_top i_sdec_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.serial_i(SER), .tgt_rdata_i(trd), .tgt_ready_i(trdy),
		.tgt_resp_i(trsp), .sel_o(sel), .byte_en_o(be), .rsp_o(rsp));
	task automatic results();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// A hung handshake must still reach the verdict
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: %s %h not %h", $time, m, s, e);
		end
	endtask : chk
	// Target 0 means refused; 11 and 12 are the serial words
	task automatic acc(input logic [31:0] a, input logic w,
		input logic [2:0] sz, input int t);
		logic [10:0] s;
		logic [3:0]  b;
		logic [31:0] rd;
		logic [31:0] ed;
		logic [3:0]  eb;
		logic        er;
		int          wt;
		i_sdec_master.xfer(a, w, sz, s, b, rd, er, wt);
		ed = (t == 11) ? SER[31:0] : {16'haa55, SER[47:32]};
		if (t < NTGT)
			ed = trd[t];
		eb = (sz == 3'h0) ? 4'h1 << a[1:0] :
			(sz == 3'h1) ? 4'h3 << {a[1], 1'b0} : 4'hf;
		chk({21'h0, s}, (t > 0 && t < NTGT) ? 32'h1 << t : 32'h0, "sel");
		chk({31'h0, er}, {31'h0, t == 0}, "resp");
		chk(wt, {31'h0, t == 0}, "waits");
		chk({28'h0, b}, {28'h0, eb}, "lanes");
		if (!w && t != 0)
			chk(rd, ed, "rdata");
	endtask : acc
	task automatic t_reset();
		chk(rsp.hrdata, 32'h0, "reset data");
		chk({30'h0, rsp.hready, rsp.hresp}, 32'h2, "reset resp");
	endtask : t_reset
	// Target stalls two data cycles, then ends with its own error
	task automatic t_target();
		logic [10:0] s;
		logic [3:0]  b;
		logic [31:0] rd;
		logic        er;
		int          wt;
		fork
			i_sdec_master.xfer(32'h2000_0000, 0, 2, s, b, rd, er, wt);
			begin
				@(negedge clk_i);
				trdy = 11'h7f7;
				trsp = 11'h008;
				repeat (3) @(negedge clk_i);
				trdy = 11'h7ff;
			end
		join
		trsp = 11'h000;
		chk({21'h0, s}, 32'h8, "stall sel");
		chk(wt, 32'h2, "stall waits");
		chk({31'h0, er}, 32'h1, "target resp");
		chk(rd, trd[3], "stall rdata");
	endtask : t_target
	task automatic t_code();
		acc(32'h0, 0, 2, 1); // Low boot copy
		acc(32'h7fc, 0, 2, 1);
		acc(32'h800, 0, 2, 0); // Past 2 kB
		acc(32'h1000_0000, 0, 2, 1);
		acc(32'h1004_0000, 0, 2, 2);
		acc(32'h1006_7ffc, 0, 2, 2);
		acc(32'h1006_8000, 0, 2, 0);
		acc(32'h1004_0000, 1, 2, 0); // Flash write
		acc(32'h0, 1, 2, 0); // ROM write
	endtask : t_code
	task automatic t_ram();
		// Radio-owned range 0x200000c0-0x200002cb left alone
		acc(32'h2000_0000, 0, 2, 3);
		acc(32'h2000_2ffc, 1, 2, 3);
		acc(32'h2000_3000, 0, 2, 4);
		acc(32'h2000_5ffc, 0, 2, 4);
		acc(32'h2000_6000, 0, 2, 0);
		acc(32'h3fff_fffc, 1, 2, 0);
		acc(32'h2000_0003, 0, 0, 3); // Top byte lane
		acc(32'h2000_0002, 1, 1, 3); // Upper half
	endtask : t_ram
	task automatic t_periph();
		acc(32'h4000_0000, 0, 2, 5);
		acc(32'h40f0_0ffc, 0, 2, 5);
		acc(32'h4050_0000, 0, 2, 0);
		acc(32'h4060_0000, 1, 2, 0);
		acc(32'h4100_0000, 0, 2, 0);
		acc(32'h4800_0000, 0, 2, 5);
		acc(32'h4810_0000, 1, 2, 5);
		acc(32'h5000_0000, 0, 2, 0);
	endtask : t_periph
	task automatic t_fast();
		// Narrow sizes here break the word-only duty on purpose
		acc(32'ha000_0000, 0, 2, 6);
		acc(32'ha000_0001, 0, 0, 0);
		acc(32'hb000_0000, 0, 2, 7);
		acc(32'hb000_0002, 1, 1, 0);
		acc(32'hc000_0000, 0, 2, 8);
		acc(32'hc000_0400, 1, 2, 9);
		acc(32'hc000_0402, 0, 1, 0);
	endtask : t_fast
	task automatic t_ppb();
		acc(32'he000_0000, 0, 2, 10);
		acc(32'he00f_fffc, 1, 2, 10);
		acc(32'he010_0000, 0, 2, 0);
		acc(32'hf000_0000, 0, 2, 0);
	endtask : t_ppb
	task automatic t_serial();
		acc(32'h1000_07f4, 0, 2, 11);
		acc(32'h1000_07f8, 0, 2, 12);
		acc(32'h1000_07f4, 1, 2, 0);
	endtask : t_serial
	initial begin
		for (int i = 0; i < NTGT; i++)
			trd[i] = 32'hd000_0000 | i;
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_reset();
		t_code();
		t_ram();
		t_periph();
		t_fast();
		t_ppb();
		t_serial();
		t_target();
		results();
	end
endmodule : tb_top
`default_nettype wire
